/* design/csfs_decim.sv */
// modulator rate divider and window averaging of the delta-sigma bit stream
`timescale 1ns/1ps
module csfs_decim
  import csfs_pkg::*;
#(
  parameter int DIV = MOD_DIV,
  parameter int SAMPLES = WINDOW_SAMPLES
) (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // control
  input wire logic start,
  input wire logic abort,
  input wire logic mod_bit,
  // result
  output logic done,
  output logic [CODE_W-1:0] code
);
  logic [7:0] div_cnt;
  logic [9:0] sample_cnt;
  logic [9:0] ones;
  logic active;
  logic mod_en;
  logic last_sample;
  logic [13:0] scaled;

  assign mod_en = active && (div_cnt == 8'(DIV - 1));
  assign last_sample = mod_en && (sample_cnt == 10'(SAMPLES - 1));
  assign scaled = 14'({ones + 10'(mod_bit), 4'h0});

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      div_cnt <= 8'h00;
      sample_cnt <= 10'h000;
      ones <= 10'h000;
      active <= 1'b0;
      done <= 1'b0;
      code <= 12'h000;
    end else begin
      done <= 1'b0;
      if (start || abort) begin
        active <= start && !abort;
        div_cnt <= 8'h00;
        sample_cnt <= 10'h000;
        ones <= 10'h000;
      end else if (active) begin
        div_cnt <= mod_en ? 8'h00 : div_cnt + 8'h01;
        if (mod_en) begin
          sample_cnt <= sample_cnt + 10'h001;
          ones <= ones + 10'(mod_bit);
        end
        if (last_sample) begin
          // a full window of ones would overflow by one code
          active <= 1'b0;
          done <= 1'b1;
          code <= (scaled > 14'(FULL_CODE)) ? FULL_CODE : scaled[CODE_W-1:0];
        end
      end
    end
  end
endmodule

/* design/csfs_pkg.sv */
// shared constants and types for the cell conversion and fault supervision block
package csfs_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int MOD_HZ = 512_000;
  localparam int MOD_DIV = CLK_HZ / MOD_HZ;
  localparam int WINDOW_US = 500;
  localparam int WINDOW_SAMPLES = (MOD_HZ / 1000) * WINDOW_US / 1000;
  localparam int SETTLE_US = 500;
  localparam int SETTLE_CYCLES = SETTLE_US * (CLK_HZ / 1_000_000);
  localparam int NUM_CELLS = 12;
  localparam int CODE_W = 12;
  localparam int CODE_SHIFT = 4;

  localparam logic [CODE_W-1:0] ZERO_CODE = 12'h200;
  localparam logic [CODE_W-1:0] BUSY_CODE = 12'hfff;
  localparam logic [CODE_W-1:0] FULL_CODE = 12'hfff;

  localparam logic [5:0] REG_CTRL = 6'h00;
  localparam logic [5:0] REG_CMD = 6'h04;
  localparam logic [5:0] REG_DISCHARGE = 6'h08;
  localparam logic [5:0] REG_TEMP = 6'h0c;
  localparam logic [5:0] REG_CELL_BASE = 6'h10;

  localparam int CTRL_TEN_BIT = 0;
  localparam int CTRL_IDX_LSB = 4;
  localparam int CMD_NORMAL_BIT = 0;
  localparam int CMD_OPEN_BIT = 1;
  localparam int CMD_SINGLE_BIT = 2;
  localparam int TEMP_FLAG_BIT = 0;
  localparam int TEMP_HOT_BIT = 1;

  localparam logic [11:0] DISCHARGE_RST = 12'h000;

  typedef struct packed {
    logic [3:0] single_idx;
    logic ten_cell_select;
  } csfs_ctrl_t;

  localparam csfs_ctrl_t CTRL_RST = '{single_idx: 4'h0, ten_cell_select: 1'b0};

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SETTLE = 2'b01,
    ST_CONV = 2'b11,
    ST_NEXT = 2'b10
  } csfs_state_t;
endpackage

/* design/csfs_sync.sv */
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module csfs_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // data
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] stage1;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      stage1 <= '0;
      dout <= '0;
    end else begin
      stage1 <= din;
      dout <= stage1;
    end
  end
endmodule

/* design/csfs_top.sv */
// conversion sequencer, open-wire test sources, thermal shutdown and register file
//
// The Avalon-MM slave port and the register addresses were decided locally.
`timescale 1ns/1ps
// How it works
// - each result averages the 512 kHz modulator stream over a 0.5 ms window
// - wait 500 us settling before the first conversion of a command
// - open-wire command turns on test current sources for all its conversions
// - discharge outputs pull high, usable as digital gate drives
// - thermal monitor active outside standby or while current flows
// - overtemperature resets configuration, discharge off, conversions stop
// - thermal shutdown sets the shutdown flag in the temperature group
// - reading the temperature group clears the shutdown flag unless a shutdown is still active
// - channels tied to the top input read zero volts
// - stack conversion covers 10 or 12 cells per ten-cell select
// - a single selected cell may be converted alone
// - result voltage is code minus 512 times 1.5 mV
module csfs_top
  import csfs_pkg::*;
#(
  parameter int SETTLE = SETTLE_CYCLES
) (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // avalon-mm slave
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // analog front end pins
  input wire logic mod_bit_pin,
  input wire logic die_hot_pin,
  input wire logic standby_pin,
  input wire logic current_active_pin,
  // analog control outputs
  output logic [3:0] cell_mux_sel,
  output logic converting,
  output logic open_wire_source_en,
  output logic [NUM_CELLS-1:0] discharge_output
);
  logic mod_bit;
  logic die_hot;
  logic standby;
  logic current_active;

  csfs_sync #(.W(4)) u_sync (
    .mclk(mclk),
    .resetn(resetn),
    .din({mod_bit_pin, die_hot_pin, standby_pin, current_active_pin}),
    .dout({mod_bit, die_hot, standby, current_active})
  );

  // registers and state
  csfs_ctrl_t ctrl;
  csfs_state_t state;
  csfs_state_t next_state;
  logic [15:0] settle_cnt;
  logic [3:0] cell_idx;
  logic [3:0] last_idx;
  logic owt_mode;
  logic thermal_shutdown_flag;
  logic [CODE_W-1:0] cell_result_code [NUM_CELLS];
  logic bus_ack;

  // bus decode
  wire bus_req = (avs_read || avs_write) && !bus_ack;
  wire wr_take = avs_write && bus_ack;
  wire rd_take = avs_read && bus_ack;
  wire [5:0] word_addr = {avs_address[5:2], 2'b00};
  wire sel_ctrl = word_addr == REG_CTRL;
  wire sel_cmd = word_addr == REG_CMD;
  wire sel_dis = word_addr == REG_DISCHARGE;
  wire sel_temp = word_addr == REG_TEMP;
  wire sel_cell = word_addr >= REG_CELL_BASE;
  wire [3:0] cell_raddr = 4'(avs_address[5:2] - REG_CELL_BASE[5:2]);

  // thermal supervision
  wire monitor_en = !standby || current_active;
  wire shutdown = monitor_en && die_hot;
  wire read_temperature_group_cmd = rd_take && sel_temp;

  // command decode
  wire busy = state != ST_IDLE;
  wire cmd_write = wr_take && sel_cmd && !busy && !shutdown;
  wire cell_convert_cmd = cmd_write && avs_writedata[CMD_NORMAL_BIT];
  wire open_wire_convert_cmd = cmd_write && avs_writedata[CMD_OPEN_BIT];
  wire single_cmd = avs_writedata[CMD_SINGLE_BIT];
  wire start_cmd = cell_convert_cmd || open_wire_convert_cmd;

  // sequencer
  wire settle_done = settle_cnt == 16'(SETTLE - 1);
  wire conv_done;
  wire [CODE_W-1:0] conv_code;
  wire conv_start = (state == ST_SETTLE && settle_done) || state == ST_NEXT;

  function automatic logic [3:0] stack_last(input logic ten);
    stack_last = ten ? 4'd9 : 4'(NUM_CELLS - 1);
  endfunction

  csfs_decim u_decim (
    .mclk(mclk),
    .resetn(resetn),
    .start(conv_start),
    .abort(shutdown),
    .mod_bit(mod_bit),
    .done(conv_done),
    .code(conv_code)
  );

  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: if (start_cmd) next_state = ST_SETTLE;
      ST_SETTLE: if (settle_done) next_state = ST_CONV;
      ST_CONV: if (conv_done) next_state = (cell_idx == last_idx) ? ST_IDLE : ST_NEXT;
      ST_NEXT: next_state = ST_CONV;
    endcase
    if (shutdown) next_state = ST_IDLE;
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      settle_cnt <= 16'h0000;
    end else begin
      settle_cnt <= (state == ST_SETTLE && !settle_done) ? settle_cnt + 16'h0001 : 16'h0000;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cell_idx <= 4'h0;
      last_idx <= 4'h0;
      owt_mode <= 1'b0;
    end else if (start_cmd) begin
      // single cell or whole stack
      cell_idx <= single_cmd ? ctrl.single_idx : 4'h0;
      last_idx <= single_cmd ? ctrl.single_idx : stack_last(ctrl.ten_cell_select);
      owt_mode <= open_wire_convert_cmd;
    end else if (state == ST_CONV && conv_done && cell_idx != last_idx) begin
      cell_idx <= cell_idx + 4'h1;
    end
  end

  // sources stay on through settling too, so the pin is already pulled when sampled
  assign open_wire_source_en = busy && owt_mode;
  assign converting = busy;
  assign cell_mux_sel = cell_idx;

  // result storage, zero-volt code after reset
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CELLS; gi++) begin : g_cell
      always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
          cell_result_code[gi] <= ZERO_CODE;
        end else if (state == ST_CONV && conv_done && cell_idx == 4'(gi)) begin
          // a channel strapped to the top input averages to the zero code
          cell_result_code[gi] <= conv_code;
        end
      end
    end
  endgenerate

  // configuration registers
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ctrl <= CTRL_RST;
      discharge_output <= DISCHARGE_RST;
    end else if (shutdown) begin
      ctrl <= CTRL_RST;
      discharge_output <= DISCHARGE_RST;
    end else if (wr_take) begin
      if (sel_ctrl) begin
        ctrl.ten_cell_select <= avs_writedata[CTRL_TEN_BIT];
        ctrl.single_idx <= avs_writedata[CTRL_IDX_LSB +: 4];
      end
      // a set bit drives the pin high against its pull-up load
      if (sel_dis) discharge_output <= avs_writedata[NUM_CELLS-1:0];
    end
  end

  // sticky flag: a new shutdown wins over the clearing read
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      thermal_shutdown_flag <= 1'b0;
    end else if (shutdown) begin
      thermal_shutdown_flag <= 1'b1;
    end else if (read_temperature_group_cmd) begin
      thermal_shutdown_flag <= 1'b0;
    end
  end

  // read data, one wait state on every access
  wire [3:0] cell_sel_idx = (cell_raddr < 4'(NUM_CELLS)) ? cell_raddr : 4'h0;
  wire [31:0] cell_word = busy ? 32'(BUSY_CODE) : 32'(cell_result_code[cell_sel_idx]);
  wire [31:0] rd_mux =
    sel_ctrl ? 32'({ctrl.single_idx, 3'b000, ctrl.ten_cell_select}) :
    sel_cmd ? 32'({owt_mode, busy}) :
    sel_dis ? 32'(discharge_output) :
    sel_temp ? 32'({die_hot, thermal_shutdown_flag}) :
    (sel_cell && cell_raddr < 4'(NUM_CELLS)) ? cell_word : 32'h0000_0000;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      bus_ack <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else begin
      bus_ack <= bus_req;
      if (bus_req && avs_read) avs_readdata <= rd_mux;
    end
  end

  assign avs_waitrequest = (avs_read || avs_write) && !bus_ack;

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  logic [16:0] settle_seen;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) settle_seen <= 17'h0_0000;
    else settle_seen <= (state == ST_SETTLE) ? settle_seen + 17'h0_0001 : 17'h0_0000;
  end

  a_settle_length: assert property ((state == ST_SETTLE && next_state == ST_CONV)
    |-> settle_seen == 17'(SETTLE - 1)) else $error("settling time wrong");
  a_owt_sources: assert property (busy |-> open_wire_source_en == owt_mode)
    else $error("test sources not tracking command");
  a_normal_no_src: assert property (busy && !owt_mode |-> !open_wire_source_en)
    else $error("sources on in normal conversion");
  a_shutdown_reset: assert property (shutdown |=> ctrl == CTRL_RST
    && discharge_output == DISCHARGE_RST && !busy) else $error("config not reset");
  a_flag_set: assert property (shutdown |=> thermal_shutdown_flag)
    else $error("shutdown flag not set");
  a_flag_clear: assert property (read_temperature_group_cmd && !shutdown
    |=> !thermal_shutdown_flag) else $error("flag not cleared by read");
  a_flag_sticky: assert property (thermal_shutdown_flag && !read_temperature_group_cmd
    |=> thermal_shutdown_flag) else $error("flag dropped without read");
  a_monitor_gate: assert property (standby && !current_active |-> !shutdown)
    else $error("monitor active in standby");
  a_ten_cell_last: assert property (start_cmd && !single_cmd && ctrl.ten_cell_select
    |=> last_idx == 4'd9) else $error("ten cell range wrong");
  a_single_cell: assert property (start_cmd && single_cmd |=> cell_idx == last_idx)
    else $error("single cell range wrong");
  a_busy_code: assert property (rd_take && sel_cell && busy && cell_raddr < 4'd12
    |-> avs_readdata == 32'(BUSY_CODE)) else $error("result readable while busy");
  a_wait_one: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("read wait state wrong");

  c_open_wire: cover property (open_wire_convert_cmd ##[1:1000] !busy);
  c_single: cover property (start_cmd && single_cmd);
  c_shutdown_busy: cover property (busy && shutdown);
  c_set_vs_clear: cover property (shutdown && read_temperature_group_cmd);
endmodule

/* tb/csfs_afe_model.sv */
// analog front end model: modulator stream of the selected cell and die comparator
`timescale 1ns/1ps
module csfs_afe_model
  import csfs_pkg::*;
(
  // clock
  input wire logic mclk,
  // converter side
  input wire logic [3:0] cell_mux_sel,
  input wire logic converting,
  input wire logic [NUM_CELLS-1:0] cell_level,
  input wire logic die_hot_req,
  // pins
  output logic mod_bit_pin = 1'b0,
  output logic die_hot_pin = 1'b0
);
  always @(posedge mclk) begin
    // no stream outside a conversion, so toggle rather than hold a stale level
    if (converting === 1'b1) begin
      mod_bit_pin <= cell_level[cell_mux_sel];
    end else begin
      mod_bit_pin <= ~mod_bit_pin;
    end
    die_hot_pin <= die_hot_req;
  end
endmodule

/* tb/csfs_top_tb.sv */
// self-checking bench for the conversion sequencer and thermal shutdown
`timescale 1ns/1ps
module csfs_top_tb;
  import csfs_pkg::*;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic mod_bit_pin, die_hot_pin;
  logic die_hot_req = 1'b0;
  logic standby_pin = 1'b0;
  logic current_active_pin = 1'b0;
  logic [NUM_CELLS-1:0] cell_level = 12'h004;
  logic [3:0] cell_mux_sel;
  logic converting, open_wire_source_en;
  logic [NUM_CELLS-1:0] discharge_output;
  logic [31:0] rd;
  logic [3:0] mux_seen;
  logic ow_seen;
  int errors = 0;
  int n_compared = 0;
  int cyc = 0;

  always #5 mclk = ~mclk;

  csfs_top #(.SETTLE(20)) csfs_top_inst (
    .mclk(mclk), .resetn(resetn),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .mod_bit_pin(mod_bit_pin), .die_hot_pin(die_hot_pin),
    .standby_pin(standby_pin), .current_active_pin(current_active_pin),
    .cell_mux_sel(cell_mux_sel), .converting(converting),
    .open_wire_source_en(open_wire_source_en), .discharge_output(discharge_output)
  );

  csfs_afe_model csfs_afe_model_inst (
    .mclk(mclk), .cell_mux_sel(cell_mux_sel), .converting(converting),
    .cell_level(cell_level), .die_hot_req(die_hot_req),
    .mod_bit_pin(mod_bit_pin), .die_hot_pin(die_hot_pin)
  );

  task automatic close_out;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] got);
    n_compared++;
    if (got !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, got);
    end
  endtask

  // request held until the edge that samples waitrequest low
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    @(posedge mclk);
    avs_read <= ~wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= d;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic reg_chk(input string nm, input logic [5:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    chk(nm, e, rd);
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      errors++;
      close_out();
    end
  end

  initial begin
    wait_cyc(20);
    resetn <= 1'b1;
    reg_chk("ctrl reset", REG_CTRL, 32'h0000_0000);
    reg_chk("discharge reset", REG_DISCHARGE, 32'h0000_0000);
    reg_chk("temp reset", REG_TEMP, 32'h0000_0000);
    reg_chk("cell1 reset", REG_CELL_BASE, 32'h0000_0200);
    reg_chk("cell12 reset", 6'h3c, 32'h0000_0200);
    bus(1'b1, REG_CTRL, 32'h0000_0001);
    bus(1'b1, REG_DISCHARGE, 32'h0000_0abc);
    reg_chk("ctrl ten cell", REG_CTRL, 32'h0000_0001);
    reg_chk("discharge rw", REG_DISCHARGE, 32'h0000_0abc);
    chk("discharge pins", 32'h0000_0abc, 32'(discharge_output));
    // open-wire stack conversion, later cut short by overtemperature
    bus(1'b1, REG_CMD, 32'h0000_0002);
    wait_cyc(2);
    chk("converting", 32'h0000_0001, 32'(converting));
    chk("sources on", 32'h0000_0001, 32'(open_wire_source_en));
    bus(1'b1, REG_CMD, 32'h0000_0001);
    reg_chk("cmd busy open", REG_CMD, 32'h0000_0003);
    reg_chk("cell busy", REG_CELL_BASE, 32'h0000_0fff);
    wait_cyc(40);
    chk("sources kept", 32'h0000_0001, 32'(open_wire_source_en));
    chk("first cell", 32'h0000_0000, 32'(cell_mux_sel));
    die_hot_req <= 1'b1;
    wait_cyc(6);
    chk("abort converting", 32'h0000_0000, 32'(converting));
    chk("abort sources", 32'h0000_0000, 32'(open_wire_source_en));
    chk("discharge off", 32'h0000_0000, 32'(discharge_output));
    reg_chk("ctrl default", REG_CTRL, 32'h0000_0000);
    reg_chk("temp hot", REG_TEMP, 32'h0000_0003);
    die_hot_req <= 1'b0;
    wait_cyc(6);
    reg_chk("flag sticky", REG_TEMP, 32'h0000_0001);
    reg_chk("flag cleared", REG_TEMP, 32'h0000_0000);
    // in standby the monitor only runs while current flows
    standby_pin <= 1'b1;
    bus(1'b1, REG_DISCHARGE, 32'h0000_00ff);
    die_hot_req <= 1'b1;
    wait_cyc(6);
    chk("standby no trip", 32'h0000_00ff, 32'(discharge_output));
    current_active_pin <= 1'b1;
    wait_cyc(6);
    chk("current trip", 32'h0000_0000, 32'(discharge_output));
    die_hot_req <= 1'b0;
    current_active_pin <= 1'b0;
    standby_pin <= 1'b0;
    wait_cyc(6);
    reg_chk("flag after trip", REG_TEMP, 32'h0000_0001);
    // normal single-cell conversion of cell 3, whose stream is all ones
    bus(1'b1, REG_CTRL, 32'h0000_0021);
    bus(1'b1, REG_CMD, 32'h0000_0005);
    ow_seen = 1'b0;
    mux_seen = 4'hf;
    wait_cyc(2);
    chk("single starts", 32'h0000_0001, 32'(converting));
    for (int i = 0; i < 60000 && converting !== 1'b0; i++) begin
      @(posedge mclk);
      if (open_wire_source_en !== 1'b0) ow_seen = 1'b1;
      if (i == 100) mux_seen = cell_mux_sel;
    end
    chk("single done", 32'h0000_0000, 32'(converting));
    chk("no sources", 32'h0000_0000, 32'(ow_seen));
    chk("single mux", 32'h0000_0002, 32'(mux_seen));
    reg_chk("cell3 full", 6'h18, 32'h0000_0fff);
    reg_chk("cell4 kept", 6'h1c, 32'h0000_0200);
    reg_chk("cmd idle", REG_CMD, 32'h0000_0000);
    close_out();
  end
endmodule
